// file: rtl/pbrm_top.sv
// Top: address decode, remap, abort and two serial port register windows
//
// Notes on behaviour
// - Peripheral accesses forced to aligned words
// - 16-Kbyte windows, 4-Kbyte interrupt controller window
// - Command bits: one triggers, zero ignored
// - Configuration read/write, zero after reset
// - Status read-only, writes ignored
// - Enable sets, disable clears, zeros ignored
// - Unused bits read zero; write zero
// - Interrupt is OR of status AND mask
// - Mask read, enable/disable single writes
// - Four DMA channels, rx/tx per port
// - Per channel 32-bit pointer, 16-bit count
// - Count done sets end bit, interrupts
// - Vectors occupy zero up to vector end
// - Remap bit swaps boot memory for SRAM
// - Chip selects 1-7 only after remap
// - Remap holds until reset
// - Undefined external address raises abort
// - Internal memory/peripherals never abort
`timescale 1ns/1ps
module pbrm_top (
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [31:0] ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  output logic             IRQ_SER0,
  output logic             IRQ_SER1,
  output logic             REMAPPED,
  output logic             ABORT,
  output logic             LOW_IS_SRAM,
  output logic             VEC_HIT
);
  // ==========================================================================
  // Request shaping
  // ==========================================================================
  pbrm_pkg::pbrm_req_t req;     // Aligned request
  logic                periph;  // Address in peripheral space
  logic                intmem;  // Address in internal memory space
  logic [7:0]          slot;    // 16-Kbyte slot index in peripheral space
  logic                sel0;    // Serial port 0 window
  logic                sel1;    // Serial port 1 window
  logic                sel_ebu; // External bus unit window
  logic                sel_icu; // Interrupt controller 4-Kbyte window
  logic [31:0]         rd0;     // Serial port 0 read data
  logic [31:0]         rd1;     // Serial port 1 read data
  logic                irq0;    // Serial port 0 interrupt
  logic                irq1;    // Serial port 1 interrupt
  logic                remap;   // Remap latched
  logic [2:0]          ext_cs;  // External chip select number
  logic                ext_def; // External address defined
  logic [31:0]         next_rdata; // Read data for next cycle

  assign req.wr    = WR;
  assign req.rd    = RD;
  assign req.addr  = {ADDR[31:2], 2'b00};
  assign req.wdata = WDATA;

  // Space decode
  assign periph  = req.addr >= pbrm_pkg::PERIPH_BASE;
  assign intmem  = req.addr <= pbrm_pkg::INTMEM_TOP;
  assign slot    = req.addr[pbrm_pkg::WIN_BITS+7:pbrm_pkg::WIN_BITS];
  assign sel0    = periph && slot == pbrm_pkg::SLOT_SER0;
  assign sel1    = periph && slot == pbrm_pkg::SLOT_SER1;
  assign sel_ebu = periph && slot == pbrm_pkg::SLOT_EBU;
  // Interrupt controller decodes only its low 4 Kbytes of its slot
  assign sel_icu = periph && slot == pbrm_pkg::SLOT_ICU
                   && req.addr[pbrm_pkg::WIN_BITS-1:pbrm_pkg::ICU_WIN_BITS] == 2'b00;

  // External space: 16-Mbyte defined region per chip select
  assign ext_cs  = req.addr[26:24];
  assign ext_def = req.addr[31:27] == 5'h00 && !intmem
                   && (ext_cs == 3'h0 || remap);

  // ==========================================================================
  // Two serial port windows, each with two DMA channels
  // ==========================================================================
  pbrm_serial_regs u_ser0 (
    .clk   (REF_CLK),
    .rst   (SYS_RST),
    .req   (req),
    .sel   (sel0),
    .rdata (rd0),
    .irq   (irq0)
  );
  pbrm_serial_regs u_ser1 (
    .clk   (REF_CLK),
    .rst   (SYS_RST),
    .req   (req),
    .sel   (sel1),
    .rdata (rd1),
    .irq   (irq1)
  );

  // ==========================================================================
  // Remap: set by writing one, cleared only by reset
  // ==========================================================================
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      remap <= 1'b0;
    end else if (WR && sel_ebu && req.addr[13:0] == pbrm_pkg::OFF_REMAP
                 && WDATA[pbrm_pkg::REMAP_BIT]) begin
      remap <= 1'b1;
    end
  end

  // ==========================================================================
  // Read data, one cycle after the read strobe
  // ==========================================================================
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (!RD) begin
      next_rdata = 32'h0000_0000;
    end else if (sel0) begin
      next_rdata = rd0;
    end else if (sel1) begin
      next_rdata = rd1;
    end else if (sel_ebu && req.addr[13:0] == pbrm_pkg::OFF_REMAP) begin
      next_rdata[pbrm_pkg::REMAP_BIT] = remap;
    end else if (sel_icu) begin
      // Controller registers sit outside this block; its window reads zero
      next_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      RDATA <= 32'h0000_0000;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // ==========================================================================
  // Registered outputs: interrupts, remap state, abort, vector hit
  // ==========================================================================
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      IRQ_SER0    <= 1'b0;
      IRQ_SER1    <= 1'b0;
      REMAPPED    <= 1'b0;
      LOW_IS_SRAM <= 1'b0;
    end else begin
      IRQ_SER0    <= irq0;
      IRQ_SER1    <= irq1;
      REMAPPED    <= remap;
      LOW_IS_SRAM <= remap;
    end
  end

  // Abort only for undefined external addresses, never internal
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ABORT   <= 1'b0;
      VEC_HIT <= 1'b0;
    end else begin
      ABORT   <= (WR || RD) && !periph && !intmem && !ext_def;
      VEC_HIT <= (WR || RD) && req.addr < pbrm_pkg::VECTOR_END;
    end
  end
endmodule : pbrm_top

// file: inc/pbrm_pkg.sv
// Package: constants and carriers for the peripheral bus register model
package pbrm_pkg;
  // ==========================================================================
  // Address map
  // ==========================================================================
  localparam logic [31:0] PERIPH_BASE  = 32'hffc0_0000; // Top four megabytes
  localparam logic [31:0] INTMEM_TOP   = 32'h003f_ffff; // Low four megabytes
  localparam logic [31:0] VECTOR_END   = 32'h0000_0020; // End of exception vectors
  localparam int          WIN_BITS     = 14;            // 16-Kbyte peripheral window
  localparam int          ICU_WIN_BITS = 12;            // 4-Kbyte controller window
  localparam logic [7:0]  SLOT_ICU     = 8'hff;         // Interrupt controller slot
  localparam logic [7:0]  SLOT_SER0    = 8'h00;         // Serial port 0 slot
  localparam logic [7:0]  SLOT_SER1    = 8'h01;         // Serial port 1 slot
  localparam logic [7:0]  SLOT_EBU     = 8'h02;         // External bus unit slot
  localparam logic [7:0]  SLOT_ICU_REG = 8'hfe;         // Unused; the interrupt controller window decodes in slot SLOT_ICU
  localparam logic [25:0] EXT_DEF_SIZE = 26'h100_0000;  // Defined bytes per chip select
  // ==========================================================================
  // Register offsets inside a serial port window, and the external bus unit remap control
  // ==========================================================================
  localparam logic [13:0] OFF_CMD    = 14'h0000; // Command, write-only
  localparam logic [13:0] OFF_CFG    = 14'h0004; // Configuration
  localparam logic [13:0] OFF_IEN    = 14'h0008; // Interrupt enable
  localparam logic [13:0] OFF_IDIS   = 14'h000c; // Interrupt disable
  localparam logic [13:0] OFF_IMASK  = 14'h0010; // Interrupt mask
  localparam logic [13:0] OFF_STAT   = 14'h0014; // Status, read-only
  localparam logic [13:0] OFF_STCLR  = 14'h0018; // Write one to clear sticky status
  localparam logic [13:0] OFF_RXPTR  = 14'h0030; // Receive pointer
  localparam logic [13:0] OFF_RXCNT  = 14'h0034; // Receive count
  localparam logic [13:0] OFF_TXPTR  = 14'h0038; // Transmit pointer
  localparam logic [13:0] OFF_TXCNT  = 14'h003c; // Transmit count
  localparam logic [13:0] OFF_REMAP  = 14'h0000; // Remap control in external bus unit
  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int          CMD_RXSTEP = 0;        // Command: one receive transfer
  localparam int          CMD_TXSTEP = 1;        // Command: one transmit transfer
  localparam int          ST_RXEND   = 0;        // Status: receive end of transfer
  localparam int          ST_TXEND   = 1;        // Status: transmit end of transfer
  localparam int          REMAP_BIT  = 0;        // Remap command bit
  localparam int          STAT_W     = 2;        // Used status bits
  localparam int          CFG_W      = 8;        // Used configuration bits
  localparam logic [7:0]  CFG_RST    = 8'h00;    // Configuration reset value
  localparam logic [31:0] PTR_RST    = 32'h0000_0000;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
    logic [31:0] addr;  // Word-aligned byte address
    logic [31:0] wdata; // Write data
  } pbrm_req_t;
  typedef struct packed {
    logic [31:0] ptr;   // Memory address pointer
    logic [15:0] cnt;   // Remaining transfers
  } pbrm_dma_t;
endpackage : pbrm_pkg

// file: rtl/pbrm_serial_regs.sv
// One serial port register window: command, config, mask, status, two DMA channels
`timescale 1ns/1ps
module pbrm_serial_regs (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire pbrm_pkg::pbrm_req_t req,
  input  wire logic              sel,
  output logic [31:0]            rdata,
  output logic                   irq
);
  // ==========================================================================
  // State
  // ==========================================================================
  logic [pbrm_pkg::CFG_W-1:0]  cfg;   // Configuration
  logic [pbrm_pkg::STAT_W-1:0] mask;  // Interrupt mask
  logic [pbrm_pkg::STAT_W-1:0] stat;  // Sticky end-of-transfer bits
  pbrm_pkg::pbrm_dma_t         rx;    // Receive channel
  pbrm_pkg::pbrm_dma_t         tx;    // Transmit channel
  logic [13:0]                 off;   // Offset inside the window
  logic                        wr;    // Write into this window
  logic                        rx_step; // Receive transfer command
  logic                        tx_step; // Transmit transfer command
  logic                        rx_done; // Receive count reaches zero
  logic                        tx_done; // Transmit count reaches zero

  assign off     = req.addr[13:0];
  assign wr      = req.wr & sel;
  // Ones trigger, zeros do nothing
  assign rx_step = wr && off == pbrm_pkg::OFF_CMD && req.wdata[pbrm_pkg::CMD_RXSTEP];
  assign tx_step = wr && off == pbrm_pkg::OFF_CMD && req.wdata[pbrm_pkg::CMD_TXSTEP];
  assign rx_done = rx_step && rx.cnt == 16'h0001;
  assign tx_done = tx_step && tx.cnt == 16'h0001;

  // Configuration register, zero after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= pbrm_pkg::CFG_RST;
    end else if (wr && off == pbrm_pkg::OFF_CFG) begin
      cfg <= req.wdata[pbrm_pkg::CFG_W-1:0];
    end
  end

  // Mask set by enable, cleared by disable
  always_ff @(posedge clk) begin
    if (rst) begin
      mask <= '0;
    end else if (wr && off == pbrm_pkg::OFF_IEN) begin
      mask <= mask | req.wdata[pbrm_pkg::STAT_W-1:0];
    end else if (wr && off == pbrm_pkg::OFF_IDIS) begin
      mask <= mask & ~req.wdata[pbrm_pkg::STAT_W-1:0];
    end
  end

  // Sticky status: set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      stat <= '0;
    end else begin
      if (wr && off == pbrm_pkg::OFF_STCLR) begin
        stat <= stat & ~req.wdata[pbrm_pkg::STAT_W-1:0];
      end
      if (rx_done) begin
        stat[pbrm_pkg::ST_RXEND] <= 1'b1;
      end
      if (tx_done) begin
        stat[pbrm_pkg::ST_TXEND] <= 1'b1;
      end
    end
  end

  // Receive channel: pointer advances a word per transfer, count falls
  always_ff @(posedge clk) begin
    if (rst) begin
      rx <= '{ptr: pbrm_pkg::PTR_RST, cnt: pbrm_pkg::CNT_RST};
    end else if (wr && off == pbrm_pkg::OFF_RXPTR) begin
      rx.ptr <= req.wdata;
    end else if (wr && off == pbrm_pkg::OFF_RXCNT) begin
      rx.cnt <= req.wdata[15:0];
    end else if (rx_step && rx.cnt != 16'h0000) begin
      rx.ptr <= rx.ptr + 32'h0000_0004;
      rx.cnt <= rx.cnt - 16'h0001;
    end
  end

  // Transmit channel
  always_ff @(posedge clk) begin
    if (rst) begin
      tx <= '{ptr: pbrm_pkg::PTR_RST, cnt: pbrm_pkg::CNT_RST};
    end else if (wr && off == pbrm_pkg::OFF_TXPTR) begin
      tx.ptr <= req.wdata;
    end else if (wr && off == pbrm_pkg::OFF_TXCNT) begin
      tx.cnt <= req.wdata[15:0];
    end else if (tx_step && tx.cnt != 16'h0000) begin
      tx.ptr <= tx.ptr + 32'h0000_0004;
      tx.cnt <= tx.cnt - 16'h0001;
    end
  end

  // Read mux; unused bits, command and unknown offsets read zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (off == pbrm_pkg::OFF_CFG) begin
      rdata[pbrm_pkg::CFG_W-1:0] = cfg;
    end else if (off == pbrm_pkg::OFF_IMASK) begin
      rdata[pbrm_pkg::STAT_W-1:0] = mask;
    end else if (off == pbrm_pkg::OFF_STAT) begin
      rdata[pbrm_pkg::STAT_W-1:0] = stat;
    end else if (off == pbrm_pkg::OFF_RXPTR) begin
      rdata = rx.ptr;
    end else if (off == pbrm_pkg::OFF_RXCNT) begin
      rdata[15:0] = rx.cnt;
    end else if (off == pbrm_pkg::OFF_TXPTR) begin
      rdata = tx.ptr;
    end else if (off == pbrm_pkg::OFF_TXCNT) begin
      rdata[15:0] = tx.cnt;
    end
  end

  // Interrupt source: status AND mask, ORed together
  assign irq = |(stat & mask);
endmodule : pbrm_serial_regs

// file: verification/pbrm_top_sva.sv
// Checker: port-level assertions for the register model top
`timescale 1ns/1ps
module pbrm_top_sva (
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        IRQ_SER0,
  input wire logic        IRQ_SER1,
  input wire logic        REMAPPED,
  input wire logic        ABORT,
  input wire logic        LOW_IS_SRAM,
  input wire logic        VEC_HIT
);
  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  wire logic acc = WR | RD;                              // Any access
  wire logic per = ADDR[31:22] == 10'h3ff;               // Peripheral space
  wire logic ext = !per && ADDR > pbrm_pkg::INTMEM_TOP;  // External space
  // Undefined external place: above chip selects, or cs1-7 before remap
  wire logic bad = ext && (ADDR[31:27] != 5'h0 || (ADDR[26:24] != 3'h0 && !REMAPPED));
  // Above all chip selects: undefined whatever the remap state
  wire logic und_hi = ext && ADDR[31:27] != 5'h0;
  // Chip selects 1 to 7: undefined until the remap has landed
  wire logic cs_up = ext && ADDR[31:27] == 5'h0 && ADDR[26:24] != 3'h0;
  // Remap bit written to the external bus unit
  wire logic rmw = WR && per && ADDR[21:14] == pbrm_pkg::SLOT_EBU && ADDR[13:2] == 12'h0
                   && WDATA[0];
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // ==========================================================================
  // Steps and assertions
  // ==========================================================================
  sequence s_remap_wr;   // Remap bit written to the external bus unit
    rmw;
  endsequence
  sequence s_mask_off0;  // Both interrupt sources of port 0 disabled
    WR && ADDR[31:2] == 30'h3ff0_0003 && WDATA[1:0] == 2'b11;
  endsequence
  sequence s_rd_stat0;   // Status of port 0 read
    RD && ADDR[31:2] == 30'h3ff0_0005;
  endsequence
  a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero outside a read");
  a_remap_sets: assert property (s_remap_wr |-> ##2 REMAPPED)
    else $error("remap write did not take");
  a_remap_holds: assert property (REMAPPED |=> REMAPPED)
    else $error("remap undone without reset");
  a_low_follows: assert property ($rose(LOW_IS_SRAM) |-> $past(rmw, 2))
    else $error("low region select differs from remap");
  a_ext_abort: assert property ((acc && (und_hi || cs_up)) ##1 (!REMAPPED || $past(und_hi))
                                |-> ABORT)
    else $error("no abort on undefined external address");
  a_abort_cause: assert property (ABORT |-> $past(acc && bad))
    else $error("abort without undefined external access");
  a_vector_hit: assert property (VEC_HIT == $past(acc && ADDR < pbrm_pkg::VECTOR_END))
    else $error("vector hit wrong");
  a_mask_off: assert property (s_mask_off0 |-> ##2 !IRQ_SER0)
    else $error("interrupt stays after disable");
  a_stat_unused: assert property (s_rd_stat0 |=> RDATA[31:2] == 30'h0)
    else $error("unused status bits not zero");
endmodule : pbrm_top_sva

bind pbrm_top pbrm_top_sva u_sva (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ_SER0(IRQ_SER0),
  .IRQ_SER1(IRQ_SER1), .REMAPPED(REMAPPED), .ABORT(ABORT),
  .LOW_IS_SRAM(LOW_IS_SRAM), .VEC_HIT(VEC_HIT));

// file: verification/pbrm_cpu_model.sv
// Bus master model standing in for the processor core
`timescale 1ns/1ps
module pbrm_cpu_model (
  input  wire logic        clk,
  input  wire logic [31:0] rdata,
  input  wire logic        abort,
  input  wire logic        vec_hit,
  output logic [31:0]      addr,
  output logic [31:0]      wdata,
  output logic             wr,
  output logic             rd
);
  logic got_abort;  // Abort seen with the last read
  logic got_vec;    // Vector hit seen with the last read
  initial begin
    addr  = 32'h0;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // One write cycle; callers keep unused bits zero
  // Callers may reach chip selects 1 to 7 before the remap, to provoke an abort
  task automatic write(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;  // Released data shows no stale value
  endtask : write
  // One read cycle; answer taken in the cycle after the strobe
  task automatic read(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d         = rdata;
    got_abort = abort;
    got_vec   = vec_hit;
  endtask : read
endmodule : pbrm_cpu_model

// file: verification/tb_pbrm_top.sv
// Testbench: registers, DMA, interrupts, remap and abort
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_pbrm_top;
  logic        clk, rst, wr, rd, irq0, irq1, remapped, abort, low_sram, vec_hit;
  logic [31:0] addr, wdata, rdata, d;
  int          mismatches, tests_run;
  always #4 clk = ~clk;  // 125 MHz
  pbrm_top DUT (.REF_CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .IRQ_SER0(irq0), .IRQ_SER1(irq1), .REMAPPED(remapped),
    .ABORT(abort), .LOW_IS_SRAM(low_sram), .VEC_HIT(vec_hit));
  pbrm_cpu_model cpu (.clk(clk), .rdata(rdata), .abort(abort), .vec_hit(vec_hit),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  // Byte address of a register in a serial port window
  function automatic logic [31:0] pa(input int p, input logic [13:0] o);
    return pbrm_pkg::PERIPH_BASE + 32'(p) * 32'h4000 + {18'h0, o};
  endfunction : pa
  // Read and compare
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    cpu.read(a, d);
    `CHK(d, e)
  endtask : rchk
  // Interrupt line compared once the mask or status change has landed
  task automatic ichk(input int p, input logic e);
    repeat (2) @(posedge clk);
    #1;
    `CHK(p ? irq1 : irq0, e)
  endtask : ichk
  // Counts, verdict and end of run
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 2; p++) begin  // Reset values of both windows
      rchk(pa(p, pbrm_pkg::OFF_CFG), 32'h0);
      for (int c = 0; c < 4; c++) rchk(pa(p, 14'h30 + 14'(4 * c)), 32'h0);
      rchk(pa(p, pbrm_pkg::OFF_IMASK), 32'h0);
    end
    $display("test reset values done");
    cpu.write(pa(0, pbrm_pkg::OFF_CFG) + 32'h2, 32'h0000_00a5);
    rchk(pa(0, pbrm_pkg::OFF_CFG), 32'h0000_00a5);
    cpu.write(pa(0, pbrm_pkg::OFF_STAT), 32'h3);
    rchk(pa(0, pbrm_pkg::OFF_STAT), 32'h0);
    rchk(pa(0, pbrm_pkg::OFF_CMD), 32'h0);
    rchk(pa(0, 14'h0100), 32'h0);
    rchk(pa(0, pbrm_pkg::OFF_CFG), 32'h0000_00a5);
    $display("test access kinds done");
    for (int p = 0; p < 2; p++) begin  // All four channels, one step too many
      for (int c = 0; c < 2; c++) begin
        cpu.write(pa(p, 14'h30 + 14'(8 * c)), 32'hfff0_1000);
        cpu.write(pa(p, 14'h34 + 14'(8 * c)), 32'h2);
        cpu.write(pa(p, pbrm_pkg::OFF_CMD), 32'h0);
        rchk(pa(p, 14'h34 + 14'(8 * c)), 32'h2);
        repeat (3) cpu.write(pa(p, pbrm_pkg::OFF_CMD), 32'h1 << c);
        rchk(pa(p, 14'h30 + 14'(8 * c)), 32'hfff0_1008);
        rchk(pa(p, 14'h34 + 14'(8 * c)), 32'h0);
        rchk(pa(p, pbrm_pkg::OFF_STAT), c ? 32'h3 : 32'h1);
      end
    end
    $display("test transfer channels done");
    for (int p = 0; p < 2; p++) begin  // Mask, enable, disable and sticky clear
      ichk(p, 1'b0);
      cpu.write(pa(p, pbrm_pkg::OFF_IEN), 32'h2);
      ichk(p, 1'b1);
      cpu.write(pa(p, pbrm_pkg::OFF_IDIS), 32'h0);
      rchk(pa(p, pbrm_pkg::OFF_IMASK), 32'h2);
      cpu.write(pa(p, pbrm_pkg::OFF_STCLR), 32'h2);
      ichk(p, 1'b0);
      rchk(pa(p, pbrm_pkg::OFF_STAT), 32'h1);
      cpu.write(pa(p, pbrm_pkg::OFF_IDIS), 32'h3);
      rchk(pa(p, pbrm_pkg::OFF_IMASK), 32'h0);
    end
    $display("test interrupts done");
    cpu.read(32'h0000_0010, d);
    `CHK({cpu.got_vec, cpu.got_abort}, 2'b10)
    cpu.read(32'h0100_0000, d);  // Chip select 1 before remap
    `CHK(cpu.got_abort, 1'b1)
    cpu.read(32'h0030_0000, d);
    `CHK(cpu.got_abort, 1'b0)
    cpu.read(32'h1000_0000, d);
    `CHK(cpu.got_abort, 1'b1)
    cpu.read(pa(1, 14'h0200), d);
    `CHK(cpu.got_abort, 1'b0)
    cpu.write(32'hffc0_8000, 32'h1);
    cpu.read(32'h0100_0000, d);
    `CHK({cpu.got_abort, remapped, low_sram}, 3'b011)
    cpu.write(32'hffc0_8000, 32'h0);
    rchk(pa(0, pbrm_pkg::OFF_CMD), 32'h0);
    `CHK(remapped, 1'b1)
    @(posedge clk);
    rst <= 1'b1;  // Reset in mid-run drops the remap
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({remapped, low_sram}, 2'b00)
    $display("test remap and abort done");
    stop_test();
  end
endmodule : tb_pbrm_top
